/* hw/led_dim_defines.svh */
// constants for the led channel dimming controller
`ifndef LED_DIM_DEFINES_SVH
`define LED_DIM_DEFINES_SVH

// system clock and pwm timebase
`define CLK_HZ          20000000
`define PWM_STEPS       4095
`define RATE_HZ_00      220
`define RATE_HZ_01      250
`define RATE_HZ_10      280
`define RATE_HZ_11      330
`define RATE_RESET      2'h1

// channel stagger and serial clock timeout
`define STAGGER_NS      80000
`define STAG_STEPS(f)   ((64'(`STAGGER_NS) * (f) * 64'(`PWM_STEPS) \
                          + 64'd500000000) / 64'd1000000000)
`define SCL_TIMEOUT_MS  25

// serial register offsets (byte wide)
`define REG_RATE        8'h00
`define REG_CTRL        8'h01
`define REG_CHON        8'h02
`define REG_AMP         8'h10
`define REG_DLO         8'h20
`define REG_DHI         8'h28

// field positions and widths
`define CTRL_EN_BIT     0
`define CTRL_STAG_BIT   1
`define AMP_W           6
`define DLO_W           4
`define DUTY_W          12

// target address
`define ADDR_BASE       7'h30
`define ADDR_SEL_MAX    4'h9
`define I2C_BYTE_BITS   4'h8

`endif

/* hw/led_dim_pkg.sv */
// shared types of the led channel dimming controller
`default_nettype none
package led_dim_pkg;
    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] data;
    } wr_word_s;

    typedef enum logic [2:0] {
        LS_IDLE = 3'b000,
        LS_ADDR = 3'b001,
        LS_REG  = 3'b010,
        LS_DATA = 3'b011,
        LS_READ = 3'b100
    } link_state_e;
endpackage
`default_nettype wire

/* hw/duty_mem.sv */
// active duty code store with registered read
`timescale 1ns/10ps
`default_nettype none
module duty_mem #(
    parameter int W  = 12,
    parameter int D  = 8,
    parameter int AW = 3
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    // write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    // read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);
    logic [W-1:0] mem_reg [D];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_reg[raddr_i];
        end
    end
endmodule // duty_mem
`default_nettype wire

/* hw/i2c_link.sv */
// serial target front end on the link clock
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_defines.svh"
module i2c_link (
    // link clock and hold level from the core domain
    input  wire logic                  link_clk_i,
    input  wire logic                  hold_i,
    // serial pins
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe_o,
    // target address, static while hold is released
    input  wire logic [6:0]            own_addr_i,
    // written byte, toggle marks a new one
    output logic                       wr_tog_o,
    output led_dim_pkg::wr_word_s      wr_word_o
);
    import led_dim_pkg::*;

    logic [1:0]  hold_s, scl_s, sda_s;
    logic        scl_d, sda_d;
    link_state_e st_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg, ptr_reg;
    logic        ack_reg;

    // oversampling keeps any scl rate up to the top one
    always_ff @(posedge link_clk_i) begin
        hold_s <= {hold_s[0], hold_i};
        scl_s  <= {scl_s[0], scl_i};
        sda_s  <= {sda_s[0], sda_i};
        scl_d  <= scl_s[1];
        sda_d  <= sda_s[1];
        sda_o  <= 1'b0;
    end

    wire link_rst = hold_s[1];
    wire start_ev = scl_s[1] & sda_d & ~sda_s[1];
    wire stop_ev  = scl_s[1] & ~sda_d & sda_s[1];
    wire rise_ev  = scl_s[1] & ~scl_d;
    wire fall_ev  = ~scl_s[1] & scl_d;
    wire last     = bit_cnt_reg == `I2C_BYTE_BITS;
    wire addr_hit = shift_reg[7:1] == own_addr_i;

    // [RQ12] byte level transfer
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            st_reg      <= LS_IDLE;
            bit_cnt_reg <= '0;
            ack_reg     <= 1'b0;
            sda_oe_o    <= 1'b0;
            wr_tog_o    <= 1'b0;
            wr_word_o   <= '0;
            ptr_reg     <= '0;
            shift_reg   <= '0;
        end else if (start_ev) begin
            st_reg      <= LS_ADDR;
            bit_cnt_reg <= '0;
            ack_reg     <= 1'b0;
            sda_oe_o    <= 1'b0;
        end else if (stop_ev) begin
            st_reg   <= LS_IDLE;
            ack_reg  <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (rise_ev && !ack_reg && !last) begin
            shift_reg   <= {shift_reg[6:0], sda_s[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (fall_ev && ack_reg) begin
            ack_reg     <= 1'b0;
            sda_oe_o    <= 1'b0;
            bit_cnt_reg <= '0;
        end else if (fall_ev && last) begin
            unique case (st_reg)
                LS_ADDR: begin
                    ack_reg  <= addr_hit;
                    sda_oe_o <= addr_hit;
                    st_reg   <= !addr_hit ? LS_IDLE :
                                shift_reg[0] ? LS_READ : LS_REG;
                end
                LS_REG: begin
                    ptr_reg  <= shift_reg;
                    ack_reg  <= 1'b1;
                    sda_oe_o <= 1'b1;
                    st_reg   <= LS_DATA;
                end
                LS_DATA: begin
                    wr_word_o <= '{offset: ptr_reg, data: shift_reg};
                    wr_tog_o  <= ~wr_tog_o;
                    ptr_reg   <= ptr_reg + 8'h01;
                    ack_reg   <= 1'b1;
                    sda_oe_o  <= 1'b1;
                end
                LS_IDLE, LS_READ: begin
                end
                default: st_reg <= LS_IDLE;
            endcase
        end
    end

    // stop_release_a [RQ12]
    stop_release_a: assert property ( // [RQ12]
        @(posedge link_clk_i) disable iff (link_rst)
        stop_ev |=> !sda_oe_o && st_reg == LS_IDLE)
        else $error("line still driven after stop");
endmodule // i2c_link
`default_nettype wire

/* hw/led_channel_dimming_ctrl.sv */
// led channel dimming controller with serial configuration
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_defines.svh"
// Overview of operation
// [RQ1] supply and enable pin good: standby, serial port live, sinks idle
// [RQ2] host programs settings first, then sets the global enable
// [RQ3] a cleared channel on bit keeps that sink off
// [RQ4] six-bit amplitude code scales current, zero gives none
// [RQ5] twelve-bit duty code sets on time per period, zero keeps off
// [RQ6] duty takes effect only when its upper eight bits are written
// [RQ7] two-bit rate select picks 220, 250, 280 or 330 periods
// [RQ8] host changes rate select only while global enable is clear
// [RQ9] host waits 10 us after a rate write before other writes
// [RQ10] stagger bit enables channel delay, clear means none
// [RQ11] with stagger each channel rises 80 us after the one before
// [RQ12] serial clock from 10 kHz up to 1000 kHz is accepted
// [RQ13] serial clock low 25 to 35 ms abandons the transfer
// [RQ14] target address 0x30 to 0x39, low bits strapped at start
// [RQ15] supply lockout clears every serial register to default; the duty_mem codes are kept, only their commit flags clear
// [RQ16] duty counter steps about 0.97 us at 250 periods a second
// [RQ17] free period counter compared with duty, on while below
module led_channel_dimming_ctrl #(
    parameter int NCH         = 8,
    parameter int TIMEOUT_CYC = `SCL_TIMEOUT_MS * (`CLK_HZ / 1000)
) (
    // clocks and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             link_clk_i,
    // supply status and straps
    input  wire logic             supply_ok_i,
    input  wire logic             enable_pin_i,
    input  wire logic [3:0]       addr_sel_i,
    // serial pins
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_o,
    // sink controls
    output logic                  standby_o,
    output logic [NCH-1:0]        sink_on_o,
    output logic [NCH-1:0][5:0]   string_current_code_o
);
    import led_dim_pkg::*;

    localparam int IDXW = $clog2(NCH);
    localparam logic [25:0] CLK_HZ26 = 26'(`CLK_HZ);
    localparam logic [11:0] STEPS = 12'(`PWM_STEPS);
    localparam logic [6:0]  ADDR_TOP = `ADDR_BASE + 7'(`ADDR_SEL_MAX);
    localparam logic [3:0][11:0] STAG_TAB = {
        12'(`STAG_STEPS(`RATE_HZ_11)), 12'(`STAG_STEPS(`RATE_HZ_10)),
        12'(`STAG_STEPS(`RATE_HZ_01)), 12'(`STAG_STEPS(`RATE_HZ_00))};

    function automatic logic [25:0] rate_hz(input logic [1:0] r);
        unique case (r)
            2'h0: rate_hz = 26'(`RATE_HZ_00);
            2'h1: rate_hz = 26'(`RATE_HZ_01);
            2'h2: rate_hz = 26'(`RATE_HZ_10);
            2'h3: rate_hz = 26'(`RATE_HZ_11);
        endcase
    endfunction

    function automatic logic hit_ch(input logic [7:0] off,
                                    input logic [7:0] base);
        hit_ch = off[7:IDXW] == base[7:IDXW];
    endfunction

    // synchronisers and core state
    logic [1:0]        sup_s, en_s, scl_s, tog_s;
    logic              tog_d;
    logic [3:0]        asel_s1, asel_s2;
    logic              run_d_reg, hold_reg, standby_reg;
    logic [19:0]       low_cnt_reg;
    logic [6:0]        own_addr_reg;
    logic [1:0]        rate_reg;
    logic              en_reg, stag_reg;
    logic [NCH-1:0]    chon_reg, wrt_reg, sink_reg;
    logic [5:0]        amp_reg [NCH];
    logic [5:0]        amp_out_reg [NCH];
    logic [3:0]        lo_reg [NCH];
    logic [25:0]       acc_reg;
    logic [11:0]       cnt_reg;
    logic [IDXW-1:0]   sc_reg, sc_d_reg;
    logic [11:0]       duty_rd;
    logic              link_tog;
    wr_word_s          wr_word;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            {sup_s, en_s, scl_s, tog_s, tog_d} <= '0;
            asel_s1 <= '0;
            asel_s2 <= '0;
        end else begin
            sup_s   <= {sup_s[0], supply_ok_i};
            en_s    <= {en_s[0], enable_pin_i};
            scl_s   <= {scl_s[0], scl_i};
            tog_s   <= {tog_s[0], link_tog};
            tog_d   <= tog_s[1];
            asel_s1 <= addr_sel_i;
            asel_s2 <= asel_s1;
        end
    end

    // lockout and write decoding
    wire run_ok    = sup_s[1] & en_s[1];
    wire cfg_rst   = srst_i | ~run_ok;
    wire timed_out = low_cnt_reg == 20'(TIMEOUT_CYC);
    wire wr_pulse  = tog_s[1] ^ tog_d;
    wire [IDXW-1:0] wr_ch = wr_word.offset[IDXW-1:0];
    wire wr_rate = wr_pulse & (wr_word.offset == `REG_RATE);
    wire wr_ctrl = wr_pulse & (wr_word.offset == `REG_CTRL);
    wire wr_chon = wr_pulse & (wr_word.offset == `REG_CHON);
    wire wr_amp  = wr_pulse & hit_ch(wr_word.offset, `REG_AMP);
    wire wr_lo   = wr_pulse & hit_ch(wr_word.offset, `REG_DLO);
    wire wr_hi   = wr_pulse & hit_ch(wr_word.offset, `REG_DHI);
    wire [3:0] asel_c = asel_s2 > `ADDR_SEL_MAX ? `ADDR_SEL_MAX : asel_s2;

    // [RQ14] address strap capture
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            own_addr_reg <= `ADDR_BASE;
            run_d_reg    <= 1'b0;
        end else begin
            run_d_reg <= run_ok;
            if (run_ok && !run_d_reg) begin
                own_addr_reg <= `ADDR_BASE | {3'h0, asel_c};
            end
        end
    end

    // [RQ13] clock low timeout
    always_ff @(posedge clk_i) begin
        if (cfg_rst || scl_s[1]) begin
            low_cnt_reg <= '0;
        end else if (!timed_out) begin
            low_cnt_reg <= low_cnt_reg + 20'h1;
        end
    end

    // [RQ1] link held only in lockout or timeout
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hold_reg    <= 1'b1;
            standby_reg <= 1'b0;
        end else begin
            hold_reg    <= cfg_rst | timed_out;
            standby_reg <= run_ok & ~en_reg;
        end
    end

    // [RQ15] lockout restores defaults
    always_ff @(posedge clk_i) begin
        if (cfg_rst) begin
            rate_reg <= `RATE_RESET;
            en_reg   <= 1'b0;
            stag_reg <= 1'b0;
            chon_reg <= '0;
        end else begin
            if (wr_rate) rate_reg <= wr_word.data[1:0];
            if (wr_ctrl) en_reg <= wr_word.data[`CTRL_EN_BIT];
            if (wr_ctrl) stag_reg <= wr_word.data[`CTRL_STAG_BIT];
            if (wr_chon) chon_reg <= wr_word.data[NCH-1:0];
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        // [RQ6] low nibble waits for upper byte
        always_ff @(posedge clk_i) begin
            if (cfg_rst) begin
                amp_reg[i] <= '0;
                lo_reg[i]  <= '0;
                wrt_reg[i] <= 1'b0;
            end else begin
                if (wr_amp && wr_ch == i) begin
                    amp_reg[i] <= wr_word.data[`AMP_W-1:0];
                end
                if (wr_lo && wr_ch == i) begin
                    lo_reg[i] <= wr_word.data[`DLO_W-1:0];
                end
                if (wr_hi && wr_ch == i) begin
                    wrt_reg[i] <= 1'b1;
                end
            end
        end

        // [RQ4] amplitude only on live channels
        always_ff @(posedge clk_i) begin
            if (cfg_rst) begin
                amp_out_reg[i] <= '0;
            end else begin
                amp_out_reg[i] <= (en_reg && chon_reg[i]) ? amp_reg[i] : '0;
            end
        end
        assign string_current_code_o[i] = amp_out_reg[i];

        // chan_off_a [RQ3]
        chan_off_a: assert property ( // [RQ3]
            @(posedge clk_i) disable iff (srst_i)
            (!chon_reg[i])[*8] |=> !sink_on_o[i])
            else $error("sink on while disabled");
        // amp_zero_a [RQ4]
        amp_zero_a: assert property ( // [RQ4]
            @(posedge clk_i) disable iff (srst_i)
            (amp_reg[i] == '0)[*8] |=> !sink_on_o[i])
            else $error("sink on at zero code");
    end

    // [RQ6] duty commit on upper byte
    duty_mem #(.W(`DUTY_W), .D(NCH), .AW(IDXW)) u_mem (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .we_i    (wr_hi),
        .waddr_i (wr_ch),
        .wdata_i ({wr_word.data, lo_reg[wr_ch]}),
        .raddr_i (sc_reg),
        .rdata_o (duty_rd)
    );

    // [RQ7] rate select drives the step accumulator
    wire [25:0] step_inc = rate_hz(rate_reg) * 26'(`PWM_STEPS);
    wire [25:0] acc_sum  = acc_reg + step_inc;
    wire        tick     = acc_sum >= CLK_HZ26;
    wire [11:0] stag_now = STAG_TAB[rate_reg];

    // [RQ16] fractional step timebase
    always_ff @(posedge clk_i) begin
        if (cfg_rst || !en_reg) begin
            acc_reg <= '0;
            cnt_reg <= '0;
        end else begin
            acc_reg <= tick ? acc_sum - CLK_HZ26 : acc_sum;
            if (tick) begin
                cnt_reg <= (cnt_reg == STEPS - 12'h1) ? '0 : cnt_reg + 12'h1;
            end
        end
    end

    // [RQ11] per channel offset of x times 80 us
    wire [11:0] ch_off = stag_reg ? 12'(sc_d_reg) * stag_now : '0;
    wire [11:0] ch_cnt = cnt_reg >= ch_off ? cnt_reg - ch_off
                                          : cnt_reg + (STEPS - ch_off);
    // [RQ17] compare count with duty
    wire on_now = en_reg & chon_reg[sc_d_reg] & wrt_reg[sc_d_reg]
                & (amp_reg[sc_d_reg] != '0) & (ch_cnt < duty_rd);

    // one channel per clock keeps a single comparator and memory port
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sc_reg   <= '0;
            sc_d_reg <= '0;
            sink_reg <= '0;
        end else begin
            sc_reg   <= sc_reg + 1'b1;
            sc_d_reg <= sc_reg;
            sink_reg[sc_d_reg] <= on_now;
        end
    end

    i2c_link u_link (
        .link_clk_i (link_clk_i),
        .hold_i     (hold_reg),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .own_addr_i (own_addr_reg),
        .wr_tog_o   (link_tog),
        .wr_word_o  (wr_word)
    );

    assign standby_o = standby_reg;
    assign sink_on_o = sink_reg;

    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence powered_s;
        run_ok && !en_reg && !timed_out;
    endsequence
    sequence scl_stuck_s;
        !scl_s[1] && low_cnt_reg == 20'(TIMEOUT_CYC - 1);
    endsequence

    standby_entry_a: assert property ( // [RQ1]
        powered_s |=> standby_o && !hold_reg)
        else $error("no standby with supply good");
    duty_zero_a: assert property ( // [RQ5]
        (duty_rd == '0) |=> !sink_on_o[$past(sc_d_reg)])
        else $error("sink on at zero duty");
    low_hold_a: assert property ( // [RQ6]
        wr_lo |-> !wr_hi && $stable(wrt_reg))
        else $error("low nibble committed duty");
    // a step is 14 to 23 clocks; a dropped enable may end the train
    step_gap_a: assert property ( // [RQ7]
        tick |=> !tick[*8] ##[6:15] (tick || !en_reg))
        else $error("step spacing out of range");
    stagger_off_a: assert property ( // [RQ10]
        !stag_reg |-> ch_cnt == cnt_reg)
        else $error("offset without stagger");
    stagger_one_a: assert property ( // [RQ11]
        stag_reg && sc_d_reg == 1 && cnt_reg >= stag_now
        |-> ch_cnt + stag_now == cnt_reg)
        else $error("stagger offset wrong");
    scl_timeout_a: assert property ( // [RQ13]
        scl_stuck_s |=> timed_out ##1 hold_reg)
        else $error("no abort on stuck clock");
    addr_range_a: assert property ( // [RQ14]
        own_addr_reg >= `ADDR_BASE && own_addr_reg <= ADDR_TOP)
        else $error("target address out of range");
    lockout_clear_a: assert property ( // [RQ15]
        !run_ok |=> !en_reg && chon_reg == '0
        && rate_reg == `RATE_RESET && !stag_reg && !standby_o)
        else $error("defaults lost");
    pwm_compare_a: assert property ( // [RQ17]
        sc_d_reg == 0 && on_now |=> sink_on_o[0])
        else $error("compare result not driven");
endmodule // led_channel_dimming_ctrl
`default_nettype wire

/* tb/i2c_host.sv */
// serial host model that writes the controller's registers
`timescale 1ns/10ps
`default_nettype none
module i2c_host #(
    parameter int Q_NS = 250
) (
    // serial pins, sda is open drain with a pull-up on the bench
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic start();
        sda_low_o = 1'b1;
        #(Q_NS);
        scl_o = 1'b0;
        #(Q_NS);
    endtask
    // bit time 4*Q_NS, top of range
    task automatic bit_out(input logic b);
        sda_low_o = ~b;
        #(Q_NS);
        scl_o = 1'b1;
        #(2*Q_NS);
        scl_o = 1'b0;
        #(Q_NS);
    endtask
    task automatic send8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
    endtask
    // sda released for the ack bit, sampled with scl high
    task automatic send(input logic [7:0] b, output logic ack);
        send8(b);
        sda_low_o = 1'b0;
        #(Q_NS);
        scl_o = 1'b1;
        #(Q_NS);
        ack = ~sda_i;
        #(Q_NS);
        scl_o = 1'b0;
        #(Q_NS);
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        #(Q_NS);
        scl_o = 1'b1;
        #(Q_NS);
        sda_low_o = 1'b0;
        #(2*Q_NS);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] off,
                      input logic [7:0] d, output logic ack);
        logic a1;
        logic a2;
        logic a3;
        start();
        send({a, 1'b0}, a1);
        send(off, a2);
        send(d, a3);
        stop();
        ack = a1 & a2 & a3;
    endtask
endmodule // i2c_host
`default_nettype wire

/* tb/led_channel_dimming_ctrl_tb.sv */
// self-checking bench of the led channel dimming controller
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_defines.svh"
module led_channel_dimming_ctrl_tb;
    logic            clk_i = 1'b0;
    logic            srst_i = 1'b1;
    logic            link_clk_i = 1'b0;
    logic            supply_ok_i = 1'b1;
    logic            enable_pin_i = 1'b1;
    logic [3:0]      addr_sel_i = 4'h5;
    logic [6:0]      addr = 7'h35;
    logic            scl, sda_low, sda_o, sda_oe_o, standby_o, ack;
    logic [7:0]      sink_on_o;
    logic [7:0][5:0] code;
    logic [1:0]      prev_on = 2'h0;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    int t0 = 0, t1 = 0, cnt0 = 0, cnt1 = 0;
    // open drain bus with pull-up
    wire logic sda = ~(sda_low | sda_oe_o);

    always #25 clk_i = ~clk_i;
    initial #1.7 forever #3 link_clk_i = ~link_clk_i;

    led_channel_dimming_ctrl #(.TIMEOUT_CYC(200)) i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .link_clk_i(link_clk_i),
        .supply_ok_i(supply_ok_i), .enable_pin_i(enable_pin_i),
        .addr_sel_i(addr_sel_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .standby_o(standby_o),
        .sink_on_o(sink_on_o), .string_current_code_o(code));
    i2c_host i_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

    // on-time counters and rise stamps of the first two sinks
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        prev_on <= sink_on_o[1:0];
        cnt0 <= cnt0 + int'(sink_on_o[0] === 1'b1);
        cnt1 <= cnt1 + int'(sink_on_o[1] === 1'b1);
        if (sink_on_o[0] === 1'b1 && prev_on[0] !== 1'b1) t0 <= cyc;
        if (sink_on_o[1] === 1'b1 && prev_on[1] !== 1'b1) t1 <= cyc;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic near(input string what, input int exp, input int got,
                        input int tol);
        n_checks++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // serial pins move on the falling clock edge, away from sampling
    task automatic w(input logic [7:0] off, input logic [7:0] d);
        @(negedge clk_i);
        i_host.wr(addr, off, d, ack);
        chk("ack", 1, ack);
    endtask

    task automatic t_standby();
        chk("standby", 1, standby_o);
        chk("sinks idle", 0, sink_on_o);
        chk("sda value", 0, sda_o);
        @(negedge clk_i);
        i_host.wr(addr - 7'h1, `REG_CTRL, 8'h01, ack);
        chk("foreign address", 0, ack);
        chk("standby kept", 1, standby_o);
    endtask
    task automatic t_config();
        w(`REG_CHON, 8'h03);
        w(`REG_AMP, 8'h3F);
        w(`REG_AMP + 8'h1, 8'h20);
        w(`REG_DLO, 8'h00);
        w(`REG_DHI, 8'h01);
        w(`REG_DLO + 8'h1, 8'h0F);
        chk("code before enable", 0, code[0]);
    endtask
    task automatic t_rates();
        int hz[4] = '{`RATE_HZ_00, `RATE_HZ_01, `RATE_HZ_10, `RATE_HZ_11};
        int c0;
        int c1;
        for (int r = 0; r < 4; r++) begin
            w(`REG_CTRL, 8'h00);
            w(`REG_RATE, 8'(r));
            cycles(200);
            c0 = cnt0;
            c1 = cnt1;
            w(`REG_CTRL, 8'h01);
            cycles(1200);
            near("on time", 16 * `CLK_HZ / (hz[r] * `PWM_STEPS),
                 cnt0 - c0, 16);
            chk("low byte only", 0, cnt1 - c1);
            chk("amp0", 8'h3F, code[0]);
            chk("amp1", 8'h20, code[1]);
            chk("amp2 off", 0, code[2]);
        end
    endtask
    task automatic t_stagger();
        w(`REG_CTRL, 8'h00);
        w(`REG_DHI + 8'h1, 8'h00);
        w(`REG_CTRL, 8'h01);
        cycles(2000);
        near("no stagger", 0, t1 - t0, 10);
        w(`REG_CTRL, 8'h00);
        w(`REG_CTRL, 8'h03);
        cycles(2500);
        near("stagger", `STAGGER_NS / 50, t1 - t0, 30);
    endtask
    task automatic t_chan_off();
        int c0;
        w(`REG_CTRL, 8'h00);
        w(`REG_CHON, 8'h02);
        c0 = cnt0;
        w(`REG_CTRL, 8'h01);
        cycles(1200);
        chk("ch0 off", 0, cnt0 - c0);
        chk("amp0 off", 0, code[0]);
        chk("amp1 kept", 8'h20, code[1]);
    endtask
    task automatic t_timeout();
        @(negedge clk_i);
        i_host.start();
        i_host.send8({addr, 1'b0});
        cycles(4);
        chk("ack held", 1, sda_oe_o);
        cycles(300);
        chk("timeout release", 0, sda_oe_o);
        @(negedge clk_i);
        i_host.stop();
        w(`REG_CTRL, 8'h00);
        chk("standby", 1, standby_o);
    endtask
    task automatic t_uvlo();
        int c0;
        w(`REG_CTRL, 8'h01);
        cycles(1);
        supply_ok_i <= 1'b0;
        addr_sel_i <= 4'hF;
        cycles(10);
        chk("standby lockout", 0, standby_o);
        supply_ok_i <= 1'b1;
        addr = 7'h39;
        cycles(40);
        chk("standby again", 1, standby_o);
        chk("codes cleared", 0, {31'h0, |code});
        c0 = cnt1;
        w(`REG_CTRL, 8'h01);
        cycles(1200);
        chk("amp1 default", 0, code[1]);
        chk("ch1 default", 0, cnt1 - c0);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog, the sequence needs about 30000 cycles
    initial begin
        cycles(90000);
        n_mismatch++;
        results();
    end

    initial begin
        cycles(3);
        srst_i <= 1'b0;
        cycles(40);
        t_standby();
        t_config();
        t_rates();
        t_stagger();
        t_chan_off();
        t_timeout();
        t_uvlo();
        results();
    end
endmodule // led_channel_dimming_ctrl_tb
`default_nettype wire
